/* core/pad_cal_pkg.sv */
package pad_cal_pkg;

  // ----------------------------------------------------------------
  // Bus geometry
  // ----------------------------------------------------------------
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int REG_W  = 16;
  localparam int IDX_W  = 6;
  localparam int LANES  = 2;

  // Register indices; byte address is four times the index
  localparam logic [IDX_W-1:0] OVERRIDE_IDX = 6'h18;
  localparam logic [IDX_W-1:0] TARGET_IDX   = 6'h19;

  // ----------------------------------------------------------------
  // Field layout
  // ----------------------------------------------------------------
  localparam int SUPPLY_BIT = 13;
  localparam int LOW_V_BIT  = 12;
  localparam int CODE_W     = 3;
  localparam int STRAP_W    = 2;

  localparam logic [REG_W-1:0] SUPPLY_MASK      = 16'h2000;
  localparam logic [REG_W-1:0] SELF_CLEAR_MASK  = 16'h8000;
  localparam logic [REG_W-1:0] OVERRIDE_WR_MASK = 16'hafcf;
  localparam logic [REG_W-1:0] TARGET_WR_MASK   = 16'hffff;

  // Supply group encodings
  localparam logic SUPPLY_3V3 = 1'b0;
  localparam logic SUPPLY_2V5 = 1'b1;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [3:0]       TRIM_HI_RST  = 4'h0;
  localparam logic [3:0]       TRIM_LO_RST  = 4'h0;
  localparam logic [REG_W-1:0] OVERRIDE_RST = {4'h0, TRIM_HI_RST, 4'h0, TRIM_LO_RST};
  localparam logic [REG_W-1:0] TARGET_RST   = 16'h0003;

  // ----------------------------------------------------------------
  // Responses and states
  // ----------------------------------------------------------------
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {
    STRAP_WAIT,
    STRAP_SETTLE,
    STRAP_LOAD,
    STRAP_DONE
  } strap_state_t;

endpackage

/* core/reg_access_if.sv */
`timescale 1ns/1ps
interface reg_access_if;
  logic        ready;
  logic        wr_en;
  logic [5:0]  wr_idx;
  logic [15:0] wr_data;
  logic [1:0]  wr_strb;
  logic        wr_hit;
  logic        rd_en;
  logic [5:0]  rd_idx;
  logic [15:0] rd_data;
  logic        rd_hit;

  modport bus  (input ready, wr_hit, rd_data, rd_hit,
                output wr_en, wr_idx, wr_data, wr_strb, rd_en, rd_idx);
  modport regs (output ready, wr_hit, rd_data, rd_hit,
                input wr_en, wr_idx, wr_data, wr_strb, rd_en, rd_idx);
endinterface

/* core/axi_lite_front.sv */
`timescale 1ns/1ps
module axi_lite_front (
  input  wire logic                          clk,
  input  wire logic                          rst_b,
  input  wire logic [pad_cal_pkg::ADDR_W-1:0] s_axi_awaddr,
  input  wire logic                          s_axi_awvalid,
  output logic                               s_axi_awready,
  input  wire logic [pad_cal_pkg::DATA_W-1:0] s_axi_wdata,
  input  wire logic [3:0]                    s_axi_wstrb,
  input  wire logic                          s_axi_wvalid,
  output logic                               s_axi_wready,
  output logic [1:0]                         s_axi_bresp,
  output logic                               s_axi_bvalid,
  input  wire logic                          s_axi_bready,
  input  wire logic [pad_cal_pkg::ADDR_W-1:0] s_axi_araddr,
  input  wire logic                          s_axi_arvalid,
  output logic                               s_axi_arready,
  output logic [pad_cal_pkg::DATA_W-1:0]     s_axi_rdata,
  output logic [1:0]                         s_axi_rresp,
  output logic                               s_axi_rvalid,
  input  wire logic                          s_axi_rready,
  reg_access_if.bus                          ra
);

  logic                            aw_held;
  logic                            w_held;
  logic [pad_cal_pkg::IDX_W-1:0]   aw_idx;
  logic [pad_cal_pkg::REG_W-1:0]   w_data;
  logic [1:0]                      w_strb;
  wire                             aw_take;
  wire                             w_take;

  // ----------------------------------------------------------------
  // Handshakes; nothing is taken until the strap load is done
  // ----------------------------------------------------------------
  assign s_axi_awready = ra.ready & ~aw_held & ~s_axi_bvalid;
  assign s_axi_wready  = ra.ready & ~w_held & ~s_axi_bvalid;
  assign s_axi_arready = ra.ready & ~s_axi_rvalid;
  assign aw_take       = s_axi_awvalid & s_axi_awready;
  assign w_take        = s_axi_wvalid & s_axi_wready;

  assign ra.wr_en   = aw_held & w_held & ~s_axi_bvalid;
  assign ra.wr_idx  = aw_idx;
  assign ra.wr_data = w_data;
  assign ra.wr_strb = w_strb;
  assign ra.rd_en   = s_axi_arvalid & s_axi_arready;
  assign ra.rd_idx  = s_axi_araddr[7:2];

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      aw_held <= 1'b0;
      w_held  <= 1'b0;
      aw_idx  <= '0;
      w_data  <= '0;
      w_strb  <= '0;
    end else begin
      aw_held <= ra.wr_en ? 1'b0 : (aw_take | aw_held);
      w_held  <= ra.wr_en ? 1'b0 : (w_take | w_held);
      if (aw_take) aw_idx <= s_axi_awaddr[7:2];
      if (w_take) begin
        w_data <= s_axi_wdata[15:0];
        w_strb <= s_axi_wstrb[1:0];
      end
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= pad_cal_pkg::RESP_OKAY;
    end else if (ra.wr_en) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= ra.wr_hit ? pad_cal_pkg::RESP_OKAY : pad_cal_pkg::RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= '0;
      s_axi_rresp  <= pad_cal_pkg::RESP_OKAY;
    end else if (ra.rd_en) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= {16'h0000, ra.rd_data};
      s_axi_rresp  <= ra.rd_hit ? pad_cal_pkg::RESP_OKAY : pad_cal_pkg::RESP_SLVERR;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  bresp_hold_a: assert property (@(posedge clk) disable iff (!rst_b)
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("Write response dropped before bready");

endmodule

/* core/output_pad_calibration_regs.sv */
// Decided for this implementation: the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
// How it works
// R1: Supply select bit 13: 0 means 3.3V/1.8V group, 1 means 2.5V/1.8V group.
// R2: After hardware reset, strap pattern 00/11 gives 3.3V group, 10/01 gives 2.5V.
// R3: Supply select reads 3.3V group until strap load or software changes it.
// R4: Bit 12 is read-only and shows 1 when the pad supply is 1.8V.
// R5: Software writes only zero into reserved bits 15, 7 and 6.
// R6: Software reads reserved fields 11:8 and 3:0 and writes them back unchanged.
// R7: Three-bit impedance code resets to 011; higher codes mean lower impedance.
// R8: Software reset keeps both registers; only hardware reset reloads defaults.
module output_pad_calibration_regs (
  input  wire logic                            clk,
  input  wire logic                            rst_b,
  input  wire logic [pad_cal_pkg::STRAP_W-1:0] config_strap,
  input  wire logic                            pad_supply_1v8,
  input  wire logic [pad_cal_pkg::ADDR_W-1:0]  s_axi_awaddr,
  input  wire logic                            s_axi_awvalid,
  output logic                                 s_axi_awready,
  input  wire logic [pad_cal_pkg::DATA_W-1:0]  s_axi_wdata,
  input  wire logic [3:0]                      s_axi_wstrb,
  input  wire logic                            s_axi_wvalid,
  output logic                                 s_axi_wready,
  output logic [1:0]                           s_axi_bresp,
  output logic                                 s_axi_bvalid,
  input  wire logic                            s_axi_bready,
  input  wire logic [pad_cal_pkg::ADDR_W-1:0]  s_axi_araddr,
  input  wire logic                            s_axi_arvalid,
  output logic                                 s_axi_arready,
  output logic [pad_cal_pkg::DATA_W-1:0]       s_axi_rdata,
  output logic [1:0]                           s_axi_rresp,
  output logic                                 s_axi_rvalid,
  input  wire logic                            s_axi_rready,
  output logic                                 pad_supply_sel,
  output logic [pad_cal_pkg::CODE_W-1:0]       impedance_code,
  output logic [pad_cal_pkg::REG_W-1:0]        override_word,
  output logic [pad_cal_pkg::REG_W-1:0]        target_word
);

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  reg_access_if ra ();

  pad_cal_pkg::strap_state_t        strap_state;
  pad_cal_pkg::strap_state_t        next_strap_state;
  logic [pad_cal_pkg::STRAP_W-1:0]  strap_meta;
  logic [pad_cal_pkg::STRAP_W-1:0]  strap_sync;
  logic                             low_v_meta;
  logic                             low_v_sync;
  logic [pad_cal_pkg::REG_W-1:0]    override_reg;
  logic [pad_cal_pkg::REG_W-1:0]    target_reg;
  logic [pad_cal_pkg::REG_W-1:0]    next_override;
  logic [pad_cal_pkg::REG_W-1:0]    next_target;
  logic [pad_cal_pkg::REG_W-1:0]    merged_override;
  logic [pad_cal_pkg::REG_W-1:0]    merged_target;
  wire                              strap_sel;
  wire                              load_strap;
  wire                              wr_override;
  wire                              wr_target;
  wire                              rd_override;
  wire                              rd_target;
  wire [pad_cal_pkg::REG_W-1:0]     override_view;

  // ----------------------------------------------------------------
  // Bus front end
  // ----------------------------------------------------------------
  axi_lite_front u_axi_lite_front (
    .clk           (clk),
    .rst_b         (rst_b),
    .s_axi_awaddr  (s_axi_awaddr),
    .s_axi_awvalid (s_axi_awvalid),
    .s_axi_awready (s_axi_awready),
    .s_axi_wdata   (s_axi_wdata),
    .s_axi_wstrb   (s_axi_wstrb),
    .s_axi_wvalid  (s_axi_wvalid),
    .s_axi_wready  (s_axi_wready),
    .s_axi_bresp   (s_axi_bresp),
    .s_axi_bvalid  (s_axi_bvalid),
    .s_axi_bready  (s_axi_bready),
    .s_axi_araddr  (s_axi_araddr),
    .s_axi_arvalid (s_axi_arvalid),
    .s_axi_arready (s_axi_arready),
    .s_axi_rdata   (s_axi_rdata),
    .s_axi_rresp   (s_axi_rresp),
    .s_axi_rvalid  (s_axi_rvalid),
    .s_axi_rready  (s_axi_rready),
    .ra            (ra.bus)
  );

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      strap_meta <= '0;
      strap_sync <= '0;
      low_v_meta <= 1'b0;
      low_v_sync <= 1'b0;
    end else begin
      strap_meta <= config_strap;
      strap_sync <= strap_meta;
      low_v_meta <= pad_supply_1v8;
      low_v_sync <= low_v_meta;
    end
  end

  // ----------------------------------------------------------------
  // Strap capture after reset release
  // ----------------------------------------------------------------
  // Equal strap bits pick the 3.3V group, unequal ones the 2.5V group
  assign strap_sel  = strap_sync[1] ^ strap_sync[0];  // see R2
  assign load_strap = (strap_state == pad_cal_pkg::STRAP_LOAD);
  assign ra.ready   = (strap_state == pad_cal_pkg::STRAP_DONE);

  always_comb begin
    case (strap_state)
      pad_cal_pkg::STRAP_WAIT:   next_strap_state = pad_cal_pkg::STRAP_SETTLE;
      pad_cal_pkg::STRAP_SETTLE: next_strap_state = pad_cal_pkg::STRAP_LOAD;
      pad_cal_pkg::STRAP_LOAD:   next_strap_state = pad_cal_pkg::STRAP_DONE;
      pad_cal_pkg::STRAP_DONE:   next_strap_state = pad_cal_pkg::STRAP_DONE;
      default:                   next_strap_state = pad_cal_pkg::STRAP_WAIT;
    endcase
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      strap_state <= pad_cal_pkg::STRAP_WAIT;
    end else begin
      strap_state <= next_strap_state;
    end
  end

  // ----------------------------------------------------------------
  // Decode
  // ----------------------------------------------------------------
  assign wr_override = ra.wr_en & (ra.wr_idx == pad_cal_pkg::OVERRIDE_IDX);
  assign wr_target   = ra.wr_en & (ra.wr_idx == pad_cal_pkg::TARGET_IDX);
  assign rd_override = (ra.rd_idx == pad_cal_pkg::OVERRIDE_IDX);
  assign rd_target   = (ra.rd_idx == pad_cal_pkg::TARGET_IDX);
  assign ra.wr_hit   = wr_override | wr_target;
  assign ra.rd_hit   = rd_override | rd_target;

  // Live 1.8V indication is merged in on read and never stored
  assign override_view = override_reg |
                         (16'(low_v_sync) << pad_cal_pkg::LOW_V_BIT);  // see R4
  assign ra.rd_data    = rd_override ? override_view :
                         rd_target   ? target_reg    : 16'h0000;

  // ----------------------------------------------------------------
  // Byte-lane write merge
  // ----------------------------------------------------------------
  for (genvar l = 0; l < pad_cal_pkg::LANES; l++) begin : g_lane
    assign merged_override[l*8 +: 8] = ra.wr_strb[l] ?
      ((override_reg[l*8 +: 8] & ~pad_cal_pkg::OVERRIDE_WR_MASK[l*8 +: 8]) |
       (ra.wr_data[l*8 +: 8] & pad_cal_pkg::OVERRIDE_WR_MASK[l*8 +: 8])) :
      override_reg[l*8 +: 8];
    assign merged_target[l*8 +: 8] = ra.wr_strb[l] ?
      ((target_reg[l*8 +: 8] & ~pad_cal_pkg::TARGET_WR_MASK[l*8 +: 8]) |
       (ra.wr_data[l*8 +: 8] & pad_cal_pkg::TARGET_WR_MASK[l*8 +: 8])) :
      target_reg[l*8 +: 8];
  end

  // Bit 15 self-clears one cycle after any write that sets it
  assign next_override =
    load_strap  ? ((override_reg & ~pad_cal_pkg::SUPPLY_MASK) |
                   ({16{strap_sel}} & pad_cal_pkg::SUPPLY_MASK)) :  // see R2
    wr_override ? merged_override :                                 // see R6
                  (override_reg & ~pad_cal_pkg::SELF_CLEAR_MASK);
  assign next_target = wr_target ? merged_target : target_reg;

  // ----------------------------------------------------------------
  // Registers; only the hardware reset reloads them
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      override_reg <= pad_cal_pkg::OVERRIDE_RST;  // see R3
      target_reg   <= pad_cal_pkg::TARGET_RST;    // see R7
    end else begin
      override_reg <= next_override;              // see R8
      target_reg   <= next_target;
    end
  end

  assign pad_supply_sel = override_reg[pad_cal_pkg::SUPPLY_BIT];  // see R1
  assign impedance_code = target_reg[pad_cal_pkg::CODE_W-1:0];   // see R7
  assign override_word  = override_reg;
  assign target_word    = target_reg;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  supply_output_a: assert property (@(posedge clk) disable iff (!rst_b)  // see R1
    wr_override && ra.wr_strb[1] |=> pad_supply_sel == $past(ra.wr_data[13]))
    else $error("Supply select does not follow the written bit");

  strap_load_a: assert property (@(posedge clk) disable iff (!rst_b)  // see R2
    load_strap |=> pad_supply_sel == ($past(strap_sync[1]) ^ $past(strap_sync[0])))
    else $error("Supply select not derived from strap pattern");

  initial_group_a: assert property (@(posedge clk) disable iff (!rst_b)  // see R3
    strap_state != pad_cal_pkg::STRAP_DONE && !$past(load_strap)
      |-> pad_supply_sel == pad_cal_pkg::SUPPLY_3V3 &&
          !s_axi_awready && !s_axi_wready && !s_axi_arready)
    else $error("Supply group not 3.3V before strap load");

  low_v_read_a: assert property (@(posedge clk) disable iff (!rst_b)  // see R4
    ra.rd_en && rd_override |=> s_axi_rvalid &&
      s_axi_rdata[12] == $past(low_v_sync) && s_axi_rdata[31:16] == 16'h0000)
    else $error("Read of 1.8V flag wrong");

  self_clear_a: assert property (@(posedge clk) disable iff (!rst_b)
    override_reg[15] && !wr_override |=> !override_reg[15])
    else $error("Bit 15 failed to self-clear");

  ro_zero_a: assert property (@(posedge clk) disable iff (!rst_b)
    override_reg[14] == 1'b0 && override_reg[5:4] == 2'h0 && override_reg[12] == 1'b0)
    else $error("Read-only reserved bits stored a value");

  code_write_a: assert property (@(posedge clk) disable iff (!rst_b)  // see R7
    $changed(impedance_code) |-> $past(wr_target) && $past(ra.wr_strb[0]) &&
      impedance_code == $past(ra.wr_data[2:0]))
    else $error("Impedance code changed without a write");

  retain_a: assert property (@(posedge clk) disable iff (!rst_b)  // see R8
    ra.ready && !wr_override && !load_strap
      |=> (override_reg & ~pad_cal_pkg::SELF_CLEAR_MASK) ==
          ($past(override_reg) & ~pad_cal_pkg::SELF_CLEAR_MASK))
    else $error("Override register changed without a write");

  bad_addr_a: assert property (@(posedge clk) disable iff (!rst_b)
    ra.rd_en && !ra.rd_hit |=> s_axi_rresp == pad_cal_pkg::RESP_SLVERR &&
      s_axi_rdata == 32'h0000_0000)
    else $error("Unmapped read not answered with error");

endmodule

/* testbench/output_pad_calibration_regs_tb.sv */
`timescale 1ns/1ps
module output_pad_calibration_regs_tb;

  // ----------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------
  localparam logic [7:0] OVR_ADDR = {pad_cal_pkg::OVERRIDE_IDX, 2'b00};
  localparam logic [7:0] TGT_ADDR = {pad_cal_pkg::TARGET_IDX, 2'b00};
  localparam logic [7:0] BAD_ADDR = 8'h40;
  localparam logic [1:0] OKAY     = pad_cal_pkg::RESP_OKAY;
  localparam logic [1:0] SLVERR   = pad_cal_pkg::RESP_SLVERR;
  localparam int         LIMIT    = 50;

  logic        clk;
  logic        rst_b;
  logic [1:0]  config_strap;
  logic        pad_supply_1v8;
  logic [7:0]  s_axi_awaddr;
  logic        s_axi_awvalid;
  logic        s_axi_awready;
  logic [31:0] s_axi_wdata;
  logic [3:0]  s_axi_wstrb;
  logic        s_axi_wvalid;
  logic        s_axi_wready;
  logic [1:0]  s_axi_bresp;
  logic        s_axi_bvalid;
  logic        s_axi_bready;
  logic [7:0]  s_axi_araddr;
  logic        s_axi_arvalid;
  logic        s_axi_arready;
  logic [31:0] s_axi_rdata;
  logic [1:0]  s_axi_rresp;
  logic        s_axi_rvalid;
  logic        s_axi_rready;
  logic        pad_supply_sel;
  logic [2:0]  impedance_code;
  logic [15:0] override_word;
  logic [15:0] target_word;
  logic [31:0] v;
  logic [1:0]  resp;
  int          n_fail;
  int          n_checks;

  output_pad_calibration_regs u_output_pad_calibration_regs (
    .clk(clk), .rst_b(rst_b), .config_strap(config_strap), .pad_supply_1v8(pad_supply_1v8),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .pad_supply_sel(pad_supply_sel),
    .impedance_code(impedance_code), .override_word(override_word), .target_word(target_word)
  );

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // ----------------------------------------------------------------
  // Reporting
  // ----------------------------------------------------------------
  task automatic final_report();
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  task automatic give_up();
    n_fail++;
    $display("[ERR] %0t wait limit reached", $time);
    final_report();
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  // ----------------------------------------------------------------
  // Bus tasks
  // ----------------------------------------------------------------
  // Readies are looked at mid-cycle; the next rising edge is the handshake
  task automatic axi_write(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
                           output logic [1:0] r);
    int   n;
    logic aw_hit;
    logic w_hit;
    logic aw_done;
    logic w_done;
    n = 0;
    aw_done = 1'b0;
    w_done = 1'b0;
    @(posedge clk);
    s_axi_awaddr <= a;
    s_axi_awvalid <= 1'b1;
    s_axi_wdata <= d;
    s_axi_wstrb <= s;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (!(aw_done && w_done)) begin
      if (n++ == LIMIT) give_up();
      @(negedge clk);
      aw_hit = !aw_done && (s_axi_awready === 1'b1);
      w_hit = !w_done && (s_axi_wready === 1'b1);
      @(posedge clk);
      if (aw_hit) begin
        s_axi_awvalid <= 1'b0;
        aw_done = 1'b1;
      end
      if (w_hit) begin
        s_axi_wvalid <= 1'b0;
        w_done = 1'b1;
      end
    end
    n = 0;
    do begin
      if (n++ == LIMIT) give_up();
      @(negedge clk);
    end while (s_axi_bvalid !== 1'b1);
    r = s_axi_bresp;
    @(posedge clk);
    s_axi_bready <= 1'b0;
  endtask

  task automatic axi_read(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    int n;
    n = 0;
    @(posedge clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      if (n++ == LIMIT) give_up();
      @(negedge clk);
    end while (s_axi_arready !== 1'b1);
    @(posedge clk);
    s_axi_arvalid <= 1'b0;
    n = 0;
    do begin
      if (n++ == LIMIT) give_up();
      @(negedge clk);
    end while (s_axi_rvalid !== 1'b1);
    d = s_axi_rdata;
    r = s_axi_rresp;
    @(posedge clk);
    s_axi_rready <= 1'b0;
  endtask

  task automatic read_expect(input logic [7:0] a, input logic [31:0] exp, input logic [1:0] er);
    logic [31:0] d;
    logic [1:0]  r;
    axi_read(a, d, r);
    check(d, exp);
    check(32'(r), 32'(er));
  endtask

  task automatic write_expect(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
                              input logic [1:0] er);
    logic [1:0] r;
    axi_write(a, d, s, r);
    check(32'(r), 32'(er));
  endtask

  // Hardware reset with strap and supply levels applied before release
  task automatic hw_reset(input logic [1:0] strap, input logic low_v);
    @(posedge clk);
    rst_b <= 1'b0;
    config_strap <= strap;
    pad_supply_1v8 <= low_v;
    repeat (5) @(posedge clk);
    check(32'(pad_supply_sel), 32'h0);
    check(32'(impedance_code), 32'h3);
    check(32'(target_word), 32'h3);
    check(32'(override_word), 32'h0);
    rst_b <= 1'b1;
    // Before the strap load the 3.3V group stands and the bus is refused
    repeat (2) @(negedge clk);
    check(32'(pad_supply_sel), 32'h0);
    check(32'({s_axi_awready, s_axi_wready, s_axi_arready}), 32'h0);
  endtask

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    n_fail = 0;
    n_checks = 0;
    rst_b = 1'b0;
    config_strap = 2'b00;
    pad_supply_1v8 = 1'b0;
    s_axi_awaddr = 8'h00;
    s_axi_awvalid = 1'b0;
    s_axi_wdata = 32'h0;
    s_axi_wstrb = 4'h0;
    s_axi_wvalid = 1'b0;
    s_axi_bready = 1'b0;
    s_axi_araddr = 8'h00;
    s_axi_arvalid = 1'b0;
    s_axi_rready = 1'b0;
    for (int s = 0; s < 4; s++) begin
      hw_reset(2'(s), s[0]);
      read_expect(OVR_ADDR, {18'h0, s[1] ^ s[0], s[0], 12'h0}, OKAY);
      check(32'(pad_supply_sel), 32'(s[1] ^ s[0]));
      read_expect(TGT_ADDR, 32'h3, OKAY);
    end
    // Read-modify-write of the override word, poking read-only bits too
    axi_read(OVR_ADDR, v, resp);
    write_expect(OVR_ADDR, v | 32'h6030, 4'h3, OKAY);
    read_expect(OVR_ADDR, v | 32'h2000, OKAY);
    check(32'(pad_supply_sel), 32'h1);
    check(32'(override_word), (v | 32'h2000) & 32'hefff);
    @(posedge clk);
    pad_supply_1v8 <= 1'b0;
    repeat (3) @(posedge clk);
    read_expect(OVR_ADDR, (v | 32'h2000) & 32'hefff, OKAY);
    write_expect(OVR_ADDR, v & 32'hdfff, 4'h3, OKAY);
    read_expect(OVR_ADDR, v & 32'hcfff, OKAY);
    check(32'(pad_supply_sel), 32'h0);
    for (int c = 0; c < 8; c++) begin
      write_expect(TGT_ADDR, 32'(c), 4'h3, OKAY);
      read_expect(TGT_ADDR, 32'(c), OKAY);
      check(32'(impedance_code), 32'(c));
    end
    // Byte strobes: only the upper byte lane is written
    write_expect(TGT_ADDR, 32'hffff_ab05, 4'h2, OKAY);
    read_expect(TGT_ADDR, 32'h0000_ab07, OKAY);
    read_expect(BAD_ADDR, 32'h0, SLVERR);
    write_expect(BAD_ADDR, 32'h0000_1234, 4'hf, SLVERR);
    repeat (20) @(posedge clk);
    read_expect(TGT_ADDR, 32'h0000_ab07, OKAY);
    check(32'(target_word), 32'h0000_ab07);
    hw_reset(2'b10, 1'b0);
    read_expect(OVR_ADDR, 32'h0000_2000, OKAY);
    read_expect(TGT_ADDR, 32'h3, OKAY);
    final_report();
  end

endmodule
